// >>> hdl/crs_pkg.sv
// component resize and skew path: shared constants, types and settings
// assumes a single 200 MHz clock; stream inputs are synchronous to it
package crs_pkg;
  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam int unsigned PIX_MIN      = 32;
  localparam int unsigned PIX_MAX      = 864;
  localparam int unsigned IN_ACTIVE    = 1080;  // active input samples per line
  localparam int unsigned FILTER_COUNT = 512;
  localparam int unsigned FILT_W       = 9;     // index width for 512 filters
  localparam int unsigned PHASE_FRAC   = 5;     // luma phase in 1/32 pixel
  localparam int unsigned CPHASE_FRAC  = 3;     // chroma phase in 1/8 sample
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam logic [9:0]  PIX_RESET    = 10'h0_2D0; // 720 pixels after reset
  localparam logic [5:0]  GAIN_RESET   = 6'h20;     // unity gain 32/32
  localparam logic [7:0]  Y_BLACK      = 8'h10;
  localparam real         SRC_RATE_MHZ = 20.25;     // documented input sample rate

  // reduction of 10-bit luma to 8 bits
  typedef enum logic [1:0] {CRS_RND, CRS_TRUNC, CRS_ED1, CRS_ED2} crs_dither_e;

  // one 4:2:2 sample: luma plus multiplexed chroma
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
    logic       cb_phase;   // 1 when c carries Cb slot of pair
  } crs_pix_s;

  // per-line settings bundle
  typedef struct packed {
    logic [9:0] pix;
    logic [4:0] yskew;
    logic [2:0] cskew;
    logic [2:0] peak;
    logic [1:0] core;
  } crs_cfg_s;
endpackage

// >>> hdl/crs_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/100ps
module crs_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_clk,      // clock
  input  wire logic             i_rst_n,    // sync reset, active low
  input  wire logic             i_valid,    // write data valid
  output logic                  o_ready,    // room available
  input  wire logic [WIDTH-1:0] i_data,     // write data
  output logic                  o_valid,    // read data valid
  input  wire logic             i_ready,    // reader accepts
  output logic      [WIDTH-1:0] o_data      // read data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  wire              wr_en = i_valid && o_ready;
  wire              rd_en = o_valid && i_ready;
  wire  [AW:0]      fill  = wp - rp;

  // pointers and storage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (wr_en) wp <= wp + 1'b1;
      if (rd_en) rp <= rp + 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (wr_en) mem[wp[AW-1:0]] <= i_data;
  end
  assign o_ready = (fill != (AW+1)'(DEPTH));
  assign o_valid = (fill != '0);
  assign o_data  = mem[rp[AW-1:0]];
endmodule

// >>> hdl/crs_top.sv
// component processing: filtering, resize, skew, FIFO, luma adjust, swap
// assumes stream inputs synchronous to i_clk, one sample per i_in_valid
`timescale 1ns/100ps
module crs_top import crs_pkg::*; #(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic       i_clk,        // 200 MHz clock
  input  wire logic       i_rst_n,      // sync reset, active low
  input  wire logic       i_in_valid,   // sample strobe at source rate
  input  wire logic       i_in_active,  // active video reference flag
  input  wire logic [7:0] i_in_y,       // luma
  input  wire logic [7:0] i_in_c,       // multiplexed Cb/Cr
  input  wire logic       i_line_start, // line boundary pulse
  input  wire logic       i_line_keep,  // 0 drops the coming line
  input  wire logic [4:0] i_sync_skew,  // measured sync skew, 1/32 pixel
  input  wire logic [9:0] i_pixels_per_line_count, // output width
  input  wire logic [4:0] i_yskew,      // luma skew 1/32
  input  wire logic [2:0] i_cskew,      // chroma skew 1/8
  input  wire logic [2:0] i_peak,       // peaking strength
  input  wire logic [1:0] i_core,       // coring amount
  input  wire logic [5:0] i_gain,       // contrast, n/32
  input  wire logic [7:0] i_bright,     // brightness, signed
  input  wire logic [1:0] i_dither,     // 10-to-8 bit method
  input  wire logic       i_swap,       // exchange Cb and Cr
  input  wire logic       i_out_ready,  // downstream accepts
  output logic            o_valid,      // output sample valid
  output logic      [7:0] o_y,          // adjusted luma
  output logic      [7:0] o_c,          // chroma
  output logic            o_cb_phase,   // pair slot flag
  output logic      [8:0] o_filter_sel, // active filter index
  output logic            o_in_ready    // FIFO can take samples
);
  // ----------------------------------------------------------------------
  // per-line settings
  // ----------------------------------------------------------------------
  crs_cfg_s cfg;
  logic     keep;
  wire [9:0] pix_even = {i_pixels_per_line_count[9:1], 1'b0}; // even steps
  wire [9:0] pix_lim  = (pix_even < 10'(PIX_MIN)) ? 10'(PIX_MIN) :
                        (pix_even > 10'(PIX_MAX)) ? 10'(PIX_MAX) : pix_even;

  // filter index follows width linearly over 512 entries
  function automatic logic [8:0] filt_of(input logic [9:0] p);
    logic [19:0] t;
    t = 20'(p - 10'(PIX_MIN)) * 20'(FILTER_COUNT - 1);
    return 9'(t / 20'(PIX_MAX - PIX_MIN));
  endfunction

  // latch settings and line keep at line start
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg  <= '{pix: PIX_RESET, default: '0};
      keep <= 1'b1;
    end else if (i_line_start) begin
      cfg  <= '{pix: pix_lim, yskew: i_yskew, cskew: i_cskew,
                peak: i_peak, core: i_core};
      keep <= i_line_keep;
    end
  end
  wire [8:0] filt = filt_of(cfg.pix);

  // ----------------------------------------------------------------------
  // luma lowpass, peaking, coring
  // ----------------------------------------------------------------------
  logic [7:0] y1;
  logic [7:0] y2;
  logic [7:0] y_lp;
  wire  take = i_in_valid && i_in_active && keep;
  // cutoff: blend weight lp_w grows with width
  wire [3:0]  lp_w  = 4'(filt[8:5]);
  wire [9:0]  lp_s  = {2'b0, y1} + {2'b0, y2} + {1'b0, i_in_y, 1'b0};
  // both branches carry weight 60 in total, so flat video passes at unity
  wire [13:0] lp_m  = 14'({2'b0, y1, 2'b0}) * 14'(lp_w) +
                      14'(lp_s) * 14'(4'd15 - lp_w);
  wire [7:0]  lp_y  = 8'(lp_m / 14'd60);
  wire signed [9:0] hf = $signed({2'b0, y1}) - $signed({2'b0, y_lp});
  // peak gain at current centre, amount n/8 of the high band
  wire signed [13:0] pk = hf * $signed({1'b0, cfg.peak});
  wire signed [10:0] hf_pk = 11'(pk >>> 3);
  // coring: 0, 1/2, 1, 2 LSB in half-LSB units, independent of peak
  wire [2:0]  core_h = (cfg.core == 2'd0) ? 3'd0 : (cfg.core == 2'd1) ? 3'd1 :
                       (cfg.core == 2'd2) ? 3'd2 : 3'd4;
  wire signed [11:0] hf2 = {hf_pk, 1'b0};
  wire signed [11:0] cored = (hf2 > $signed({9'b0, core_h})) ? hf2 - $signed({9'b0, core_h}) :
                             (hf2 < -$signed({9'b0, core_h})) ? hf2 + $signed({9'b0, core_h}) :
                             12'sd0;
  wire signed [11:0] ysum = $signed({4'b0, y1}) + (cored >>> 1);
  wire [7:0]  y_pk = (ysum < 0) ? 8'h00 : (ysum > 12'sd255) ? 8'hFF : 8'(ysum);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      y1   <= '0;
      y2   <= '0;
      y_lp <= '0;
    end else if (take) begin
      y2   <= y1;
      y1   <= i_in_y;
      y_lp <= lp_y;
    end
  end

  // chroma kept per component so resizing never blends Cb with Cr
  logic       in_cb;     // next taken chroma is Cb
  logic [7:0] cb_h;
  logic [7:0] cb_p;
  logic [7:0] cr_h;
  logic [7:0] cr_p;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_cb <= 1'b1;
      cb_h  <= '0;
      cb_p  <= '0;
      cr_h  <= '0;
      cr_p  <= '0;
    end else if (i_line_start) begin
      in_cb <= 1'b1;
    end else if (take) begin
      in_cb <= ~in_cb;
      if (in_cb) begin
        cb_p <= cb_h;
        cb_h <= i_in_c;
      end else begin
        cr_p <= cr_h;
        cr_h <= i_in_c;
      end
    end
  end

  // ----------------------------------------------------------------------
  // resize phase accumulator and skew interpolation
  // ----------------------------------------------------------------------
  logic [15:0] acc;      // 1/32 pixel phase in output steps
  logic        slot;     // 1 = Cb slot of the chroma pair
  logic [9:0]  out_cnt;
  wire  [15:0] acc_n   = acc + {6'b0, cfg.pix};
  wire         emit    = take && (acc_n >= 16'(IN_ACTIVE)) && (out_cnt < cfg.pix);
  wire  [4:0]  ph      = 5'(acc[4:0] + cfg.yskew);
  wire  [12:0] yi      = 13'({5'b0, y_pk} * 13'(6'd32 - 6'(ph))) +
                         13'({5'b0, y2} * 13'(ph));
  wire  [2:0]  cph     = 3'(ph[4:2] + cfg.cskew);
  // newest and previous sample of the component that this slot carries
  wire  [7:0]  c_new   = slot ? (in_cb ? i_in_c : cb_h) : (in_cb ? cr_h : i_in_c);
  wire  [7:0]  c_old   = slot ? (in_cb ? cb_h : cb_p) : (in_cb ? cr_p : cr_h);
  wire  [10:0] ci      = 11'({3'b0, c_new} * 11'(4'd8 - 4'(cph))) +
                         11'({3'b0, c_old} * 11'(cph));
  crs_pix_s    rsz;
  assign rsz = '{y: 8'(yi >> 5), c: 8'(ci >> 3), cb_phase: slot};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc     <= '0;
      slot    <= 1'b1;
      out_cnt <= '0;
    end else if (i_line_start) begin
      acc     <= {11'b0, i_sync_skew};
      slot    <= 1'b1;
      out_cnt <= '0;
    end else if (take) begin
      acc <= (acc_n >= 16'(IN_ACTIVE)) ? acc_n - 16'(IN_ACTIVE) : acc_n;
      if (emit) begin
        slot    <= ~slot;
        out_cnt <= out_cnt + 10'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // FIFO, chroma swap, luma gain and reduction
  // ----------------------------------------------------------------------
  crs_pix_s  fq;
  crs_pix_s  fq_d;       // previous chroma of pair
  logic      f_valid;
  logic      f_ready;
  logic      w_ready;
  logic [1:0] err;
  crs_fifo #(.WIDTH($bits(crs_pix_s)), .DEPTH(DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (emit),
    .o_ready (w_ready),
    .i_data  (rsz),
    .o_valid (f_valid),
    .i_ready (f_ready),
    .o_data  (fq)
  );
  assign f_ready = !o_valid || i_out_ready;
  wire pop = f_valid && f_ready;
  // swap: both Cb and Cr slots show the held chroma of the previously popped sample (fq_d)
  wire [7:0] c_sel = !i_swap ? fq.c : (fq.cb_phase ? fq_d.c : fq_d.c);
  wire signed [15:0] g = $signed({8'b0, fq.y} * 16'(i_gain)) / 16'sd8 +
                         $signed({{6{i_bright[7]}}, i_bright, 2'b0});
  wire [9:0] y10 = (g < 0) ? 10'h000 : (g > 16'sd1023) ? 10'h3FF : 10'(g);
  wire [10:0] ed  = {1'b0, y10} + ((i_dither == 2'(CRS_ED1)) ? {9'b0, 1'b0, err[1]} :
                                   (i_dither == 2'(CRS_ED2)) ? {9'b0, err} : 11'd0);
  wire [10:0] rnd = {1'b0, y10} + 11'd2;
  wire [7:0] y8 = (i_dither == 2'(CRS_TRUNC)) ? y10[9:2] :
                  (i_dither == 2'(CRS_RND))   ? (rnd[10] ? 8'hFF : rnd[9:2]) :
                  (ed[10] ? 8'hFF : ed[9:2]);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_valid      <= 1'b0;
      o_y          <= Y_BLACK;
      o_c          <= 8'h80;
      o_cb_phase   <= 1'b1;
      fq_d         <= '0;
      err          <= '0;
      o_filter_sel <= '0;
      o_in_ready   <= 1'b0;
    end else begin
      o_filter_sel <= filt;
      o_in_ready   <= w_ready;
      if (pop) begin
        fq_d       <= fq;
        o_valid    <= 1'b1;
        o_y        <= y8;
        o_c        <= c_sel;
        o_cb_phase <= fq.cb_phase;
        err        <= ed[1:0];
      end else if (i_out_ready) begin
        o_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_width_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cfg.pix >= 10'(PIX_MIN)) && (cfg.pix <= 10'(PIX_MAX)) && !cfg.pix[0])
    else $error("width out of range");
  a_cfg_line: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_line_start) |-> $stable(cfg))
    else $error("settings changed mid line");
  a_drop_line: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !keep |-> !emit)
    else $error("dropped line emitted");
  a_skew_seed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_line_start |=> acc == {11'b0, $past(i_sync_skew)})
    else $error("skew not seeded");
  a_first_cb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_line_start |=> slot)
    else $error("line not starting with Cb");
  a_line_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    out_cnt <= cfg.pix)
    else $error("too many pixels in line");
  a_filt_track: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_filter_sel == $past(filt))
    else $error("filter index stale");
  a_fifo_path: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pop |=> o_valid && o_cb_phase == $past(fq.cb_phase))
    else $error("fifo output lost");
endmodule

// >>> testbench/crs_src_model.sv
// upstream colour decoder model: one line of flat luma, muxed Cb/Cr
// assumes the bench pulses i_go for one cycle while o_busy is low
`timescale 1ns/100ps
module crs_src_model import crs_pkg::*; (
  input  wire logic       i_clk,        // clock
  input  wire logic       i_go,         // start one line
  input  wire logic [7:0] i_y,          // flat luma level
  output logic            o_valid,      // sample strobe
  output logic            o_active,     // active video flag
  output logic      [7:0] o_y,          // luma
  output logic      [7:0] o_c,          // muxed chroma, Cb first
  output logic            o_line_start, // line boundary pulse
  output logic            o_busy        // line in progress
);
  int unsigned n;
  initial begin
    {o_valid, o_active, o_line_start, o_busy} = 4'h0;
    o_y = 8'h00;
    o_c = 8'h00;
  end
  // ---------------------------------------------------------------
  // line generator: strobe every 10 cycles, 1080 active then blanking
  // ---------------------------------------------------------------
  always begin
    @(posedge i_clk);
    if (i_go) begin
      o_busy       <= 1'b1;
      o_line_start <= 1'b1;
      @(posedge i_clk);
      o_line_start <= 1'b0;
      for (n = 0; n < IN_ACTIVE + 20; n++) begin
        // between strobes the data lines carry a toggling pattern
        repeat (9) begin
          @(posedge i_clk);
          o_valid <= 1'b0;
          o_y     <= ~o_y;
          o_c     <= ~o_c;
        end
        @(posedge i_clk);
        o_valid  <= 1'b1;
        o_active <= (n < IN_ACTIVE);
        o_y      <= i_y;
        o_c      <= n[0] ? 8'hC0 : 8'h40;
      end
      @(posedge i_clk);
      o_valid  <= 1'b0;
      o_active <= 1'b0;
      o_busy   <= 1'b0;
    end
  end
endmodule

// >>> testbench/component_resize_skew_path_tb.sv
// self-checking bench for crs_top, fed by crs_src_model
// assumes a 200 MHz clock and synchronous active-low reset
`timescale 1ns/100ps
module component_resize_skew_path_tb import crs_pkg::*;;
  logic       clk = 0, rst_n = 0, go = 0, out_ready = 1, keep = 1, swap = 0;
  logic [4:0] sync_skew = 5'h03, yskew = 5'h00;
  logic [2:0] cskew = 3'h0, peak = 3'h0;
  logic [1:0] core = 2'h0, dither = 2'h1;
  logic [5:0] gain = GAIN_RESET;
  logic [7:0] bright = 8'h00, exp_y = 8'h50, in_y = 8'h50;
  logic [9:0] pix = 10'h0_360;
  logic       s_valid, s_active, s_ls, busy, o_valid, o_cb_phase, o_in_ready;
  logic [7:0] s_y, s_c, o_y, o_c;
  logic [8:0] o_filter_sel;
  logic       chk_on = 1, saw_full = 0;
  int         cnt = 0, cycles = 0, num_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  crs_src_model src (.i_clk(clk), .i_go(go), .i_y(in_y), .o_valid(s_valid),
    .o_active(s_active), .o_y(s_y), .o_c(s_c), .o_line_start(s_ls), .o_busy(busy));
  crs_top #(.DEPTH(FIFO_DEPTH)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_in_valid(s_valid),
    .i_in_active(s_active), .i_in_y(s_y), .i_in_c(s_c), .i_line_start(s_ls),
    .i_line_keep(keep), .i_sync_skew(sync_skew), .i_pixels_per_line_count(pix),
    .i_yskew(yskew), .i_cskew(cskew), .i_peak(peak), .i_core(core), .i_gain(gain),
    .i_bright(bright), .i_dither(dither), .i_swap(swap), .i_out_ready(out_ready),
    .o_valid(o_valid), .o_y(o_y), .o_c(o_c), .o_cb_phase(o_cb_phase),
    .o_filter_sel(o_filter_sel), .o_in_ready(o_in_ready));
  // ---------------------------------------------------------------
  // comparison, verdict and hang guard
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  // output monitor: slot order, luma level and chroma per slot
  always @(posedge clk) begin
    if (s_ls) cnt <= 0;
    if (!o_in_ready) saw_full <= 1'b1;
    if (rst_n && o_valid && out_ready) begin
      cnt <= cnt + 1;
      if (chk_on) check("cb_phase", {15'h0, o_cb_phase}, {15'h0, ~cnt[0]});
      if (chk_on && cnt == 8) check("luma", {8'h0, o_y}, {8'h0, exp_y});
      if (chk_on && cnt inside {8, 9})
        check("chroma", {8'h0, o_c}, (o_cb_phase ^ swap) ? 16'h0040 : 16'h00C0);
    end
  end
  // one line through the source, then let the pipeline drain
  task automatic run_line;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy) @(posedge clk);
    repeat (60) @(posedge clk);
  endtask
  function automatic logic [15:0] sel_of(input int w);
    return 16'((w - 32) * 511 / 832);
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("rst_valid", {15'h0, o_valid}, 16'h0000);
    check("rst_y", {8'h0, o_y}, 16'h0010);
    check("rst_c", {8'h0, o_c}, 16'h0080);
    check("rst_slot", {15'h0, o_cb_phase}, 16'h0001);
    repeat (3) @(posedge clk);
    #1;
    check("rst_sel", {7'h0, o_filter_sel}, sel_of(720));
    check("rst_in_ready", {15'h0, o_in_ready}, 16'h0001);
  endtask
  task automatic t_wide;
    fork
      run_line();
      begin
        repeat (500) @(posedge clk);
        pix <= 10'h0_020;
      end
    join
    check("count_864", 16'(cnt), 16'd864);
    check("sel_864", {7'h0, o_filter_sel}, sel_of(864));
  endtask
  task automatic t_small;
    swap <= 1'b1;
    gain <= 6'h10;
    bright <= 8'h08;
    peak <= 3'h7;
    core <= 2'h3;
    yskew <= 5'h1F;
    cskew <= 3'h7;
    exp_y <= 8'h30;
    run_line();
    check("count_32", 16'(cnt), 16'd32);
    check("sel_32", {7'h0, o_filter_sel}, sel_of(32));
  endtask
  task automatic t_drop;
    pix <= 10'h0_021;
    keep <= 1'b0;
    run_line();
    check("count_drop", 16'(cnt), 16'd0);
    check("sel_odd", {7'h0, o_filter_sel}, sel_of(32));
  endtask
  task automatic t_fifo;
    pix <= 10'h0_362;
    keep <= 1'b1;
    out_ready <= 1'b0;
    chk_on <= 1'b0;
    saw_full = 1'b0;
    run_line();
    check("count_stall", 16'(cnt), 16'd0);
    check("fifo_full", {15'h0, saw_full}, 16'h0001);
    check("sel_clamp", {7'h0, o_filter_sel}, sel_of(864));
    out_ready <= 1'b1;
    repeat (200) @(posedge clk);
    check("drained", {15'h0, cnt >= FIFO_DEPTH}, 16'h0001);
  endtask
  initial begin
    t_reset();
    t_wide();
    t_small();
    t_drop();
    t_fifo();
    stop_test();
  end
endmodule
